// file: design/sbtc_pkg.sv
// constants for the sixteen-bit timer/counter
package sbtc_pkg;

  // ****************************************
  // clock source select codes
  // ****************************************
  localparam logic [1:0] SRC_INSTR = 2'h0;
  localparam logic [1:0] SRC_SYSCLK = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] SRC_LFOSC = 2'h3;

  // ****************************************
  // sizes, resets and counts
  // ****************************************
  localparam int COUNT_W = 16;
  localparam int PRESC_W = 3;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [2:0] PRESC_RESET = 3'h0;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [1:0] INSTR_RESET = 2'h0;
  localparam int EXT_SYNC_STAGES = 2;
  localparam int EXT_ASYNC_STAGES = 1;

endpackage : sbtc_pkg

// file: design/sbtc_edge_det.sv
// edge detector with a chain of sampling flops
`timescale 1ns/1ps
`default_nettype none
module sbtc_edge_det #(
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sampled level
  input wire logic levelIn,
  // edges of the last stage
  output logic riseTick,
  output logic fallTick
);

  logic [STAGES:0] chain_q;

  // with two stages or more the first flop feeds only the next one
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chain_q <= '0;
    end
    else
    begin
      chain_q <= {chain_q[STAGES-1:0], levelIn};
    end
  end

  assign riseTick = chain_q[STAGES-1] & ~chain_q[STAGES];
  assign fallTick = ~chain_q[STAGES-1] & chain_q[STAGES];

endmodule // sbtc_edge_det
`default_nettype wire

// file: design/sbtc_prescale.sv
// 1/2/4/8 prescaler ahead of the counter
`timescale 1ns/1ps
`default_nettype none
module sbtc_prescale (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic [1:0] rateSel,
  input wire logic clear,
  input wire logic tickIn,
  // division period complete
  output logic tickOut
);

  logic [2:0] presc_q;
  logic [2:0] presc_d;
  logic [2:0] lastValue;
  logic atLast;

  assign lastValue = 3'(({2'h0, 1'b1} << rateSel) - 3'h1);
  assign atLast = (presc_q == lastValue);
  assign tickOut = tickIn & atLast & ~clear;
  assign presc_d = clear ? sbtc_pkg::PRESC_RESET :
                   !tickIn ? presc_q :
                   atLast ? sbtc_pkg::PRESC_RESET : 3'(presc_q + 3'h1);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      presc_q <= sbtc_pkg::PRESC_RESET;
    end
    else
    begin
      presc_q <= presc_d;
    end
  end

  chk_clear_zero: assert property (
    @(posedge clk) disable iff (!arst_n) clear |=> presc_q == sbtc_pkg::PRESC_RESET)
    else $error("prescaler not cleared by write");

endmodule // sbtc_prescale
`default_nettype wire

// file: design/sbtc_top.sv
// sixteen-bit timer/counter with clock select, prescaler, gate and oscillator
`timescale 1ns/1ps
`default_nettype none
module sbtc_top (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control bits
  input wire logic timerOn,
  input wire logic gateEnable,
  input wire logic gatePolarity,
  input wire logic [1:0] clockSourceSelect,
  input wire logic [1:0] prescaleSelect,
  input wire logic secOscEnable,
  input wire logic syncDisable,
  input wire logic sleepMode,
  // count byte writes and flag clear
  input wire logic wrLowEn,
  input wire logic wrHighEn,
  input wire logic [7:0] wrData,
  input wire logic overflowClear,
  // clock and gate pins
  input wire logic extClockPin,
  input wire logic lowFreqInternalOsc,
  input wire logic secOscInPin,
  input wire logic gatePin,
  // count and status
  output logic [7:0] countHighByte,
  output logic [7:0] countLowByte,
  output logic overflowFlag,
  output logic wakeRequest,
  // secondary oscillator
  output logic secOscRunning,
  output logic secOscOutPin
);

  // ****************************************
  // state
  // ****************************************
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [1:0] instrDiv_q;
  logic armed_q;
  logic armed_d;
  logic overflow_q;
  logic overflow_d;
  logic wake_q;
  logic oscRun_q;
  logic oscOut_q;

  // ****************************************
  // source selection
  // ****************************************
  logic wrAny;
  logic instrTick;
  logic extRaw;
  logic extRiseSync;
  logic extFallSync;
  logic extRiseAsync;
  logic extFallAsync;
  logic lfRise;
  logic selExt;
  logic asyncExt;
  logic extRise;
  logic extFall;
  logic srcTick;
  logic gateActive;
  logic countEnable;
  logic preTick;
  logic incTick;
  logic rollOver;

  assign wrAny = wrLowEn | wrHighEn;
  assign instrTick = (instrDiv_q == sbtc_pkg::INSTR_DIV_LAST);
  // an enabled crystal takes over the external input
  assign extRaw = secOscEnable ? secOscInPin : extClockPin;
  assign selExt = (clockSourceSelect == sbtc_pkg::SRC_EXT);
  assign asyncExt = selExt & syncDisable;

  // switching the path between sync and async may lose or add one edge, accepted
  assign extRise = syncDisable ? extRiseAsync : extRiseSync;
  assign extFall = syncDisable ? extFallAsync : extFallSync;

  sbtc_edge_det #(
    .STAGES(sbtc_pkg::EXT_SYNC_STAGES)
  ) u_extSync (
    .clk(clk),
    .arst_n(arst_n),
    .levelIn(extRaw),
    .riseTick(extRiseSync),
    .fallTick(extFallSync)
  );

  sbtc_edge_det #(
    .STAGES(sbtc_pkg::EXT_ASYNC_STAGES)
  ) u_extAsync (
    .clk(clk),
    .arst_n(arst_n),
    .levelIn(extRaw),
    .riseTick(extRiseAsync),
    .fallTick(extFallAsync)
  );

  sbtc_edge_det #(
    .STAGES(1)
  ) u_lfOsc (
    .clk(clk),
    .arst_n(arst_n),
    .levelIn(lowFreqInternalOsc),
    .riseTick(lfRise),
    .fallTick()
  );

  always_comb
  begin
    case (clockSourceSelect)
      sbtc_pkg::SRC_INSTR: srcTick = instrTick;
      sbtc_pkg::SRC_SYSCLK: srcTick = 1'b1;
      sbtc_pkg::SRC_EXT: srcTick = extRise & armed_q;
      sbtc_pkg::SRC_LFOSC: srcTick = lfRise;
      default: srcTick = 1'b0;
    endcase
  end

  // ****************************************
  // enable, gate and prescaler
  // ****************************************
  assign gateActive = (gatePin == gatePolarity);
  // in sleep only the asynchronous external path still sees edges
  assign countEnable = timerOn & (!gateEnable | gateActive)
                       & (!sleepMode | asyncExt);

  sbtc_prescale u_presc (
    .clk(clk),
    .arst_n(arst_n),
    .rateSel(prescaleSelect),
    .clear(wrAny),
    .tickIn(srcTick & countEnable),
    .tickOut(preTick)
  );

  assign incTick = preTick;
  assign rollOver = incTick & (count_q == sbtc_pkg::COUNT_MAX);

  // ****************************************
  // next values
  // ****************************************
  always_comb
  begin
    count_d = count_q;
    if (wrLowEn)
    begin
      count_d[7:0] = wrData;
    end
    if (wrHighEn)
    begin
      count_d[15:8] = wrData;
    end
    if (!wrAny && incTick)
    begin
      count_d = 16'(count_q + 16'h0001);
    end
  end

  // arming is lost on disable or write and regained by a falling edge
  assign armed_d = (!timerOn || wrAny) ? 1'b0 : (armed_q | extFall);
  // a rollover in the clearing cycle still leaves the flag set
  assign overflow_d = (rollOver & !wrAny) | (overflow_q & !overflowClear);

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_q <= sbtc_pkg::COUNT_RESET;
      instrDiv_q <= sbtc_pkg::INSTR_RESET;
      armed_q <= 1'b0;
      overflow_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      instrDiv_q <= 2'(instrDiv_q + 2'h1);
      armed_q <= armed_d;
      overflow_q <= overflow_d;
      wake_q <= sleepMode & (wake_q | (rollOver & !wrAny));
    end
  end

  // oscillator amplifier runs whenever enabled, sleep has no say
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oscRun_q <= 1'b0;
      oscOut_q <= 1'b0;
    end
    else
    begin
      oscRun_q <= secOscEnable;
      oscOut_q <= secOscEnable & ~secOscInPin;
    end
  end

  assign countHighByte = count_q[15:8];
  assign countLowByte = count_q[7:0];
  assign overflowFlag = overflow_q;
  assign wakeRequest = wake_q;
  assign secOscRunning = oscRun_q;
  assign secOscOutPin = oscOut_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  chk_write_low: assert property (
    wrLowEn |=> countLowByte == $past(wrData))
    else $error("low byte write not loaded");

  chk_off_holds: assert property (
    !timerOn && !wrAny |=> $stable(count_q))
    else $error("count moved while off");

  chk_gate_holds: assert property (
    timerOn && gateEnable && !gateActive && !wrAny |=> $stable(count_q))
    else $error("count moved with gate inactive");

  chk_sysclk_rate: assert property (
    timerOn && !gateEnable && !sleepMode && !wrAny
    && clockSourceSelect == sbtc_pkg::SRC_SYSCLK && prescaleSelect == 2'h0
    |=> count_q == 16'($past(count_q) + 16'h0001))
    else $error("system clock did not count every cycle");

  chk_instr_rate: assert property (
    clockSourceSelect == sbtc_pkg::SRC_INSTR && incTick
    && $stable(clockSourceSelect) |=> !incTick [*3])
    else $error("instruction clock counted too fast");

  chk_div8_gap: assert property (
    prescaleSelect == 2'h3 && incTick && !wrAny
    |=> (!incTick || wrAny || $changed(prescaleSelect)) [*7])
    else $error("divide by eight period too short");

  chk_ext_armed: assert property (
    wrAny || !timerOn |=> !armed_q)
    else $error("external arm not cleared");

  chk_ext_need_arm: assert property (
    selExt && !armed_q |-> !incTick)
    else $error("external count without prior falling edge");

  // once cleared, the next tick is a whole division period away
  chk_presc_clear: assert property (
    wrAny && prescaleSelect != 2'h0 |=> !incTick || $changed(prescaleSelect))
    else $error("prescaler not cleared by write");

  chk_ovf_set: assert property (
    rollOver && !wrAny |=> overflowFlag && count_q == sbtc_pkg::COUNT_RESET)
    else $error("rollover did not set flag");

  chk_ovf_sticky: assert property (
    overflowFlag && !overflowClear |=> overflowFlag)
    else $error("overflow flag lost without clear");

  chk_sleep_stop: assert property (
    sleepMode && !asyncExt |-> !incTick)
    else $error("synchronous count during sleep");

  chk_osc_start: assert property (
    secOscEnable |=> secOscRunning)
    else $error("oscillator not started");

  chk_osc_stop: assert property (
    !secOscEnable |=> !secOscRunning && !secOscOutPin)
    else $error("oscillator still driven while disabled");

  chk_osc_drive: assert property (
    secOscEnable |=> secOscOutPin == !$past(secOscInPin))
    else $error("oscillator output not inverting input");

  chk_write_high: assert property (
    wrHighEn |=> countHighByte == $past(wrData))
    else $error("high byte write not loaded");

  chk_ovf_clear: assert property (
    overflowClear && !rollOver |=> !overflowFlag)
    else $error("overflow flag not cleared");

  chk_wake_drop: assert property (
    !sleepMode |=> !wakeRequest)
    else $error("wake request held while awake");

  cov_rollover: cover property (rollOver);
  cov_async_sleep: cover property (sleepMode && asyncExt && incTick);
  cov_gated: cover property (gateEnable && gateActive && incTick);
  cov_wake: cover property (wakeRequest);

endmodule // sbtc_top
`default_nettype wire

// file: tb/sbtc_clk_model.sv
// external clock source model: bursts of pulses, idle low between bursts
`timescale 1ns/1ps
`default_nettype none
module sbtc_clk_model (
  // clock
  input wire logic clk,
  // burst request
  input wire logic [7:0] pulses,
  input wire logic start,
  // pin level
  output logic pinOut
);
  logic [8:0] halves_q = 9'h000;
  logic [1:0] div_q = 2'h0;
  logic pin_q = 1'h0;

  assign pinOut = pin_q;

  // a burst opens with a rising edge, so an unarmed counter would miss it
  always @(posedge clk)
  begin
    if (start)
    begin
      halves_q <= {pulses, 1'h0};
    end
    else if (halves_q != 9'h000)
    begin
      div_q <= 2'(div_q + 2'h1);
      if (div_q == 2'h3)
      begin
        pin_q <= ~pin_q;
        halves_q <= 9'(halves_q - 9'h001);
      end
    end
  end
endmodule // sbtc_clk_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'h0;
  logic arst_n, timerOn, gateEnable, gatePolarity, secOscEnable, syncDisable, sleepMode;
  logic [1:0] clockSourceSelect, prescaleSelect;
  logic wrLowEn, wrHighEn, overflowClear, gatePin, start, pinLvl;
  logic [7:0] wrData, pulses, countHighByte, countLowByte;
  logic overflowFlag, wakeRequest, secOscRunning, secOscOutPin;
  logic [15:0] expCount;
  logic [47:0] rows [6];
  wire logic extClockPin, lowFreqInternalOsc, secOscInPin;
  wire logic [15:0] countNow;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  // one source model feeds every clock pin
  assign extClockPin = pinLvl;
  assign lowFreqInternalOsc = pinLvl;
  assign secOscInPin = pinLvl;
  assign countNow = {countHighByte, countLowByte};

  always #20 clk = ~clk;

  sbtc_top dut (.clk, .arst_n, .timerOn, .gateEnable, .gatePolarity, .clockSourceSelect,
    .prescaleSelect, .secOscEnable, .syncDisable, .sleepMode, .wrLowEn, .wrHighEn, .wrData,
    .overflowClear, .extClockPin, .lowFreqInternalOsc, .secOscInPin, .gatePin,
    .countHighByte, .countLowByte, .overflowFlag, .wakeRequest, .secOscRunning,
    .secOscOutPin);
  sbtc_clk_model partner (.clk, .pulses, .start, .pinOut(pinLvl));

  // ****************************************
  // access tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] v);
    @(posedge clk);
    wrLowEn <= 1'h1;
    wrData <= v[7:0];
    @(posedge clk);
    wrLowEn <= 1'h0;
    wrHighEn <= 1'h1;
    wrData <= v[15:8];
    @(posedge clk);
    wrHighEn <= 1'h0;
    @(posedge clk);
  endtask

  // holds the timer on for exactly n clock cycles
  task automatic run(input int n);
    @(posedge clk);
    timerOn <= 1'h1;
    tick(n);
    timerOn <= 1'h0;
    tick(3);
  endtask

  task automatic clr;
    @(posedge clk);
    overflowClear <= 1'h1;
    @(posedge clk);
    overflowClear <= 1'h0;
  endtask

  // row: source, osc enable, sync disable, sleep, preload, expected count
  task automatic ext(input logic [47:0] r);
    clockSourceSelect <= r[45:44];
    secOscEnable <= r[40];
    syncDisable <= r[36];
    wr(r[31:16]);
    clr;
    sleepMode <= r[32];
    @(posedge clk);
    timerOn <= 1'h1;
    tick(4);
    pulses <= 8'h05;
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    tick(48);
    check({15'h0000, wakeRequest}, {15'h0000, r[32] && r[15:0] < r[31:16]});
    timerOn <= 1'h0;
    sleepMode <= 1'h0;
    tick(3);
    check(countNow, r[15:0]);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      give_verdict;
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    arst_n = 1'h0;
    {timerOn, gateEnable, gatePolarity, secOscEnable, syncDisable, sleepMode} = 6'h00;
    {clockSourceSelect, prescaleSelect} = 4'h0;
    {wrLowEn, wrHighEn, overflowClear, gatePin, start} = 5'h00;
    wrData = 8'h00;
    pulses = 8'h00;
    rows = '{48'h2000_0000_0004, 48'h2010_0000_0004, 48'h2011_FFFD_0001,
      48'h2001_0000_0000, 48'h3000_0000_0005, 48'h2111_0000_0004};
    tick(16);
    arst_n <= 1'h1;
    tick(2);
    check(countNow, 16'h0000);
    check({15'h0000, overflowFlag}, 16'h0000);
    wr(16'h1234);
    clockSourceSelect <= 2'h1;
    tick(10);
    check(countNow, 16'h1234);
    $display("test reset and write done");
    for (int p = 0; p < 4; p++)
    begin
      prescaleSelect <= p[1:0];
      wr(16'h0000);
      run(16);
      check(countNow, 16'h0010 >> p);
    end
    wr(16'h0000);
    run(15);
    check(countNow, 16'h0001);
    wr(16'h0000);
    run(9);
    check(countNow, 16'h0001);
    prescaleSelect <= 2'h0;
    clockSourceSelect <= 2'h0;
    wr(16'h0000);
    run(40);
    check(countNow, 16'h000A);
    $display("test clock select and prescale done");
    clockSourceSelect <= 2'h1;
    gateEnable <= 1'h1;
    wr(16'h0000);
    expCount = 16'h0000;
    for (int g = 0; g < 4; g++)
    begin
      gatePolarity <= g[1];
      gatePin <= g[0];
      run(10);
      expCount = expCount + ((g[1] == g[0]) ? 16'h000A : 16'h0000);
      check(countNow, expCount);
    end
    gateEnable <= 1'h0;
    $display("test gate done");
    wr(16'hFC00);
    clr;
    run(1023);
    check(countNow, 16'hFFFF);
    check({15'h0000, overflowFlag}, 16'h0000);
    run(1);
    check(countNow, 16'h0000);
    check({15'h0000, overflowFlag}, 16'h0001);
    run(4);
    check({15'h0000, overflowFlag}, 16'h0001);
    clr;
    tick(2);
    check({15'h0000, overflowFlag}, 16'h0000);
    $display("test overflow done");
    for (int i = 0; i < 6; i++)
      ext(rows[i]);
    check({15'h0000, secOscRunning}, 16'h0001);
    check({15'h0000, secOscOutPin}, 16'h0001);
    $display("test external sources done");
    clockSourceSelect <= 2'h1;
    prescaleSelect <= 2'h3;
    secOscEnable <= 1'h0;
    wr(16'h00F0);
    run(5);
    check(countNow, 16'h00F0);
    check({15'h0000, secOscOutPin}, 16'h0000);
    arst_n <= 1'h0;
    tick(2);
    check(countNow, 16'h0000);
    arst_n <= 1'h1;
    tick(2);
    run(3);
    check(countNow, 16'h0000);
    run(5);
    check(countNow, 16'h0001);
    $display("test reset recovery done");
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
